// ===== hub_chk.sv
// assertions on the sensor hub master ports
`include "hub_consts.svh"
`default_nettype none
module hub_chk (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic ce, // enable
    input wire logic [7:0] reg_addr, // offset
    input wire logic reg_rd, // read
    input wire logic [7:0] reg_rdata, // read data
    input wire logic hub_page_select, // page
    input wire logic hub_irq_route_first, // route
    input wire logic accel_active, // power
    input wire logic gyro_active, // power
    input wire logic host_scl_in, // host clock
    input wire logic host_sda_in, // host data
    input wire logic first_irq_pin, // irq
    input wire logic aux_clock_pin_oe_n, // aux clock
    input wire logic aux_data_pin_oe_n, // aux data
    input wire hub_pkg::status_type hub_status // status
);
    import hub_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic idle = hub_status.round_complete;
    wire logic stat_rd = ce && reg_rd && (hub_page_select ? reg_addr == `HUB_STATE_ADDR
        : reg_addr == `HUB_MIRROR_ADDR);
    sequence start_seq;
        !aux_data_pin_oe_n && aux_clock_pin_oe_n;
    endsequence
    sequence quiet_seq;
        (idle && host_scl_in && host_sda_in)[*5];
    endsequence
    irq_rise_a: assert property ($rose(idle) && hub_irq_route_first |=> first_irq_pin)
        else $error("irq missed round end");
    irq_hold_a: assert property (first_irq_pin && !stat_rd |=> first_irq_pin)
        else $error("irq dropped without read");
    irq_clear_a: assert property (stat_rd && !$rose(idle) |=> !first_irq_pin)
        else $error("irq kept after read");
    no_power_a: assert property (idle && !accel_active && !gyro_active |=> idle)
        else $error("round without power");
    idle_release_a: assert property (quiet_seq |-> aux_clock_pin_oe_n && aux_data_pin_oe_n)
        else $error("aux bus held while idle");
    status_zero_a: assert property (hub_status.zero == 2'h0)
        else $error("status spare bits set");
    round_start_a: assert property ($fell(idle) |-> ##[1:1000] start_seq)
        else $error("no start after trigger");
    mirror_read_a: assert property (ce && reg_rd && !hub_page_select
        && reg_addr == `HUB_MIRROR_ADDR |=> reg_rdata == $past(hub_status))
        else $error("mirror read wrong");
endmodule
bind sensor_hub_i2c_master hub_chk hub_chk_inst (.clk, .rst, .ce, .reg_addr, .reg_rd,
    .reg_rdata, .hub_page_select, .hub_irq_route_first, .accel_active, .gyro_active,
    .host_scl_in, .host_sda_in, .first_irq_pin, .aux_clock_pin_oe_n, .aux_data_pin_oe_n,
    .hub_status);
`default_nettype wire

// ===== hub_consts.svh
// constants for the auxiliary two-wire sensor hub master
`ifndef HUB_CONSTS_SVH
`define HUB_CONSTS_SVH

`define HUB_CTRL_ADDR 8'h14
`define HUB_STATE_ADDR 8'h22
`define HUB_MIRROR_ADDR 8'h39
`define HUB_WBYTE_ADDR 8'h21
`define HUB_OUT_FIRST 8'h02
`define HUB_OUT_COUNT 5'h12
`define HUB_TGT_BASE 8'h15
`define HUB_TGT_STRIDE 8'h03
`define HUB_TGT_SPAN 8'h0c
`define HUB_CTRL_RESET 8'h00
`define HUB_BYTE_ZERO 8'h00
`define HUB_CLK_HZ 100000000
`define HUB_SCL_HZ 100000
`define HUB_QUARTER_CYCLES (`HUB_CLK_HZ / (`HUB_SCL_HZ * 4))
`define HUB_LAST_BIT 4'h8
`define HUB_PH_ADDR_WR 2'h0
`define HUB_PH_POINTER 2'h1
`define HUB_PH_DATA 2'h2
`define HUB_PH_ADDR_RD 2'h3

`endif

// ===== hub_pkg.sv
// types shared by the sensor hub master
`default_nettype none
package hub_pkg;
    typedef struct packed {
        logic soft_reset;
        logic single_write_mode;
        logic ext_trigger;
        logic pass_through;
        logic aux_pullup_enable;
        logic master_enable;
        logic [1:0] target_count;
    } ctrl_type;

    typedef struct packed {
        logic single_write_finished;
        logic [3:0] target_no_ack;
        logic [1:0] zero;
        logic round_complete;
    } status_type;

    typedef struct packed {
        logic hit;
        logic [1:0] index;
        logic [1:0] field;
    } tgt_hit_type;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_SETUP = 7'h02,
        ST_START = 7'h04,
        ST_SEND = 7'h08,
        ST_RECV = 7'h10,
        ST_STOP = 7'h20,
        ST_NEXT = 7'h40
    } state_type;
endpackage
`default_nettype wire

// ===== hub_target.sv
// behavioural external sensor on the auxiliary bus
`default_nettype none
module hub_target #(
    parameter logic [6:0] TGT_ADDR = 7'h2a,
    parameter logic [7:0] TGT_DATA = 8'h5c
) (
    input wire logic scl, // bus clock
    input wire logic sda, // bus data
    output logic sda_drive_n // pulls data low when 0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic act = 1'b0, first = 1'b0, ok = 1'b0, rd = 1'b0, tx = 1'b0;
    logic [7:0] sh = 8'h00;
    int cnt = 0;
    initial sda_drive_n = 1'b1;
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        first = 1'b1;
        tx = 1'b0;
        cnt = 0;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        else if (tx && sda) act = 1'b0; // master refused more data
        cnt = cnt + 1;
    end
    always @(negedge scl) begin
        if (cnt == 8 && first) begin
            ok = (sh[7:1] == TGT_ADDR);
            rd = sh[0];
        end
        if (cnt == 9) begin
            cnt = 0;
            tx = first ? rd & ok : tx;
            act = act & ok;
            first = 1'b0;
        end
        if (!act) sda_drive_n = 1'b1;
        else if (cnt == 8) sda_drive_n = tx || !ok;
        else sda_drive_n = tx ? TGT_DATA[7 - cnt] : 1'b1;
    end
endmodule
`default_nettype wire

// ===== sensor_hub_i2c_master.sv
// auxiliary two-wire master sequencer with its register page
`include "hub_consts.svh"
`default_nettype none
module sensor_hub_i2c_master (
    input wire logic clk, // 100 MHz system clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic [7:0] reg_addr, // register offset
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata, // read data, valid the cycle after reg_rd
    input wire logic hub_page_select, // 1 = hub register page mapped
    input wire logic hub_irq_route_first, // routes round complete to first irq pin
    input wire logic accel_active, // accelerometer powered
    input wire logic gyro_active, // gyroscope powered
    input wire logic data_ready, // inertial data-ready pulse, 104 Hz
    input wire logic second_irq_pin, // second interrupt pin level
    output logic second_irq_input_mode, // second interrupt pad turned to input
    output logic first_irq_pin, // hub event on first interrupt pin
    output logic aux_clock_pin_out, // aux clock drive value
    output logic aux_clock_pin_oe_n, // aux clock driven low when 0
    input wire logic aux_data_pin_in, // aux data pin level
    output logic aux_data_pin_out, // aux data drive value
    output logic aux_data_pin_oe_n, // aux data driven low when 0
    output logic aux_pullup_enable, // internal pull-ups on aux lines
    input wire logic host_scl_in, // main bus clock level
    input wire logic host_sda_in, // main bus data level
    output logic host_sda_out, // main bus data drive value
    output logic host_sda_oe_n, // main bus data driven low when 0
    output hub_pkg::status_type hub_status // live master status
);
    import hub_pkg::*;

    function automatic tgt_hit_type decode_tgt(input logic [7:0] a);
        logic [7:0] off;
        tgt_hit_type r;
        off = a - `HUB_TGT_BASE;
        r.hit = (a >= `HUB_TGT_BASE) && (off < `HUB_TGT_SPAN);
        r.index = 2'(off / `HUB_TGT_STRIDE);
        r.field = 2'(off % `HUB_TGT_STRIDE);
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] ext_meta, sda_meta, hscl_meta, hsda_meta;
    logic ext_s, sda_s, hscl_s, hsda_s;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // trigger pin idles low, the bus lines idle high
            ext_meta <= 2'h0;
            {sda_meta, hscl_meta, hsda_meta} <= 6'h3f;
        end else if (ce) begin
            ext_meta <= {ext_meta[0], second_irq_pin};
            sda_meta <= {sda_meta[0], aux_data_pin_in};
            hscl_meta <= {hscl_meta[0], host_scl_in};
            hsda_meta <= {hsda_meta[0], host_sda_in};
        end
    end
    assign ext_s = ext_meta[1];
    assign sda_s = sda_meta[1];
    assign hscl_s = hscl_meta[1];
    assign hsda_s = hsda_meta[1];

    ////////////////////////////////////////////////////////////////////////
    // register page
    ctrl_type ctrl;
    logic [7:0] tgt_addr [4];
    logic [7:0] tgt_ptr [4];
    logic [7:0] tgt_setup [4];
    logic [7:0] wbyte;
    logic [7:0] out_reg [18];
    status_type status;
    logic irq;

    wire tgt_hit_type wdec = decode_tgt(reg_addr);
    wire hub_wr = reg_wr && hub_page_select;
    wire ctrl_wr = hub_wr && (reg_addr == `HUB_CTRL_ADDR);
    wire [7:0] out_off = reg_addr - `HUB_OUT_FIRST;
    wire out_hit = (reg_addr >= `HUB_OUT_FIRST) && (out_off < 8'(`HUB_OUT_COUNT));
    wire [7:0] tgt_word = (wdec.field == 2'h0) ? tgt_addr[wdec.index] :
                          (wdec.field == 2'h1) ? tgt_ptr[wdec.index] : tgt_setup[wdec.index];
    wire [7:0] hub_word = (reg_addr == `HUB_CTRL_ADDR) ? ctrl :
                          (reg_addr == `HUB_STATE_ADDR) ? status :
                          (reg_addr == `HUB_WBYTE_ADDR) ? wbyte :
                          wdec.hit ? tgt_word :
                          out_hit ? out_reg[5'(out_off)] : `HUB_BYTE_ZERO;
    // the mirror is the only hub register visible on the main page
    wire [7:0] main_word = (reg_addr == `HUB_MIRROR_ADDR) ? status : `HUB_BYTE_ZERO;
    wire state_read = reg_rd && (hub_page_select ? (reg_addr == `HUB_STATE_ADDR)
                                                 : (reg_addr == `HUB_MIRROR_ADDR));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= `HUB_CTRL_RESET;
        end else if (ce && ctrl_wr) begin
            ctrl <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                tgt_addr[i] <= `HUB_BYTE_ZERO;
                tgt_ptr[i] <= `HUB_BYTE_ZERO;
                tgt_setup[i] <= `HUB_BYTE_ZERO;
            end
            wbyte <= `HUB_BYTE_ZERO;
        end else if (ce) begin
            if (ctrl.soft_reset) begin
                for (int i = 0; i < 4; i++) begin
                    tgt_addr[i] <= `HUB_BYTE_ZERO;
                    tgt_ptr[i] <= `HUB_BYTE_ZERO;
                    tgt_setup[i] <= `HUB_BYTE_ZERO;
                end
                wbyte <= `HUB_BYTE_ZERO;
            end else if (hub_wr) begin
                if (wdec.hit && wdec.field == 2'h0) tgt_addr[wdec.index] <= reg_wdata;
                if (wdec.hit && wdec.field == 2'h1) tgt_ptr[wdec.index] <= reg_wdata;
                if (wdec.hit && wdec.field == 2'h2) tgt_setup[wdec.index] <= reg_wdata;
                if (reg_addr == `HUB_WBYTE_ADDR) wbyte <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `HUB_BYTE_ZERO;
        end else if (ce && reg_rd) begin
            reg_rdata <= hub_page_select ? hub_word : main_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger selection
    logic [2:0] rate_cnt;
    wire [1:0] rate_sel = tgt_setup[0][7:6];
    wire [2:0] rate_mask = (rate_sel == 2'h0) ? 3'h0 : (rate_sel == 2'h1) ? 3'h1 :
                           (rate_sel == 2'h2) ? 3'h3 : 3'h7;
    wire sensors_on = accel_active || gyro_active;
    wire hub_allowed = ctrl.master_enable && sensors_on && !ctrl.soft_reset &&
                       !ctrl.pass_through;
    wire int_trig = !ctrl.ext_trigger && data_ready && ((rate_cnt & rate_mask) == 3'h0);
    wire ext_trig = ctrl.ext_trigger && ext_s;
    wire trigger = hub_allowed && (int_trig || ext_trig);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_cnt <= 3'h0;
        end else if (ce && data_ready) begin
            rate_cnt <= rate_cnt + 3'h1;
        end
    end

    assign second_irq_input_mode = ctrl.master_enable && ctrl.ext_trigger;
    assign aux_pullup_enable = ctrl.aux_pullup_enable;

    ////////////////////////////////////////////////////////////////////////
    // transaction engine
    state_type state;
    logic [1:0] tgt, phase, q;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [2:0] rd_left;
    logic [4:0] widx;
    logic [8:0] qcnt;
    logic samp, write_done, scl_low, sda_low;
    logic [3:0] no_ack;

    wire [7:0] cur_addr = tgt_addr[tgt];
    wire [2:0] cur_count = tgt_setup[tgt][2:0];
    wire cur_read = cur_addr[0];
    wire do_read = cur_read && (cur_count != 3'h0);
    wire do_write = (tgt == 2'h0) && !cur_read &&
                    !(ctrl.single_write_mode && write_done);
    wire last_tgt = (tgt == ctrl.target_count);
    wire tick = (qcnt == 9'h0);
    wire bit_end = tick && (q == 2'h3);
    wire ack_end = bit_end && (bitn == `HUB_LAST_BIT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qcnt <= 9'h0;
            q <= 2'h0;
            samp <= 1'b1;
        end else if (ce) begin
            if (state == ST_IDLE || state == ST_SETUP) begin
                qcnt <= 9'(`HUB_QUARTER_CYCLES - 1);
                q <= 2'h0;
            end else begin
                qcnt <= tick ? 9'(`HUB_QUARTER_CYCLES - 1) : qcnt - 9'h1;
                if (tick) q <= q + 2'h1;
                if (tick && q == 2'h2) samp <= sda_s;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            tgt <= 2'h0;
            phase <= `HUB_PH_ADDR_WR;
            bitn <= 4'h0;
            shreg <= `HUB_BYTE_ZERO;
            rd_left <= 3'h0;
            widx <= 5'h0;
            write_done <= 1'b0;
            no_ack <= 4'h0;
            for (int i = 0; i < 18; i++) out_reg[i] <= `HUB_BYTE_ZERO;
        end else if (ce) begin
            if (ctrl.soft_reset) begin
                state <= ST_IDLE;
                write_done <= 1'b0;
                no_ack <= 4'h0;
                for (int i = 0; i < 18; i++) out_reg[i] <= `HUB_BYTE_ZERO;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (trigger) begin
                            tgt <= 2'h0;
                            widx <= 5'h0;
                            state <= ST_SETUP;
                        end
                    end
                    ST_SETUP: begin
                        phase <= `HUB_PH_ADDR_WR;
                        state <= (do_read || do_write) ? ST_START : ST_NEXT;
                    end
                    ST_START: begin
                        if (bit_end) begin
                            shreg <= {cur_addr[7:1], phase == `HUB_PH_ADDR_RD};
                            bitn <= 4'h0;
                            state <= ST_SEND;
                        end
                    end
                    ST_SEND: begin
                        if (bit_end && bitn != `HUB_LAST_BIT) begin
                            shreg <= {shreg[6:0], 1'b0};
                            bitn <= bitn + 4'h1;
                        end
                        if (ack_end) begin
                            bitn <= 4'h0;
                            if (samp) begin
                                no_ack[tgt] <= 1'b1;
                                state <= ST_STOP;
                            end else begin
                                case (phase)
                                    `HUB_PH_ADDR_WR: begin
                                        shreg <= tgt_ptr[tgt];
                                        phase <= `HUB_PH_POINTER;
                                    end
                                    `HUB_PH_POINTER: begin
                                        if (do_read) begin
                                            phase <= `HUB_PH_ADDR_RD;
                                            state <= ST_START;
                                        end else begin
                                            shreg <= wbyte;
                                            phase <= `HUB_PH_DATA;
                                        end
                                    end
                                    `HUB_PH_DATA: begin
                                        if (ctrl.single_write_mode) write_done <= 1'b1;
                                        state <= ST_STOP;
                                    end
                                    default: begin
                                        rd_left <= cur_count;
                                        state <= ST_RECV;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_RECV: begin
                        if (bit_end && bitn != `HUB_LAST_BIT) begin
                            shreg <= {shreg[6:0], samp};
                            bitn <= bitn + 4'h1;
                        end
                        if (ack_end) begin
                            bitn <= 4'h0;
                            if (widx < `HUB_OUT_COUNT) begin
                                out_reg[widx] <= shreg;
                                widx <= widx + 5'h1;
                            end
                            rd_left <= rd_left - 3'h1;
                            if (rd_left == 3'h1) state <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (bit_end) state <= ST_NEXT;
                    end
                    ST_NEXT: begin
                        if (last_tgt || !hub_allowed) begin
                            state <= ST_IDLE;
                        end else begin
                            tgt <= tgt + 2'h1;
                            state <= ST_SETUP;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive and status
    wire sending_data = (state == ST_SEND) && (bitn != `HUB_LAST_BIT);
    wire recv_ack = (state == ST_RECV) && (bitn == `HUB_LAST_BIT) && (rd_left != 3'h1);
    wire data_phase = (state == ST_SEND) || (state == ST_RECV);
    wire next_scl_low = ctrl.pass_through ? !hscl_s :
                        (data_phase || state == ST_START) ? (q == 2'h0 || q == 2'h3) :
                        (state == ST_STOP) ? (q == 2'h0) : 1'b0;
    wire next_sda_low = ctrl.pass_through ? !hsda_s :
                        sending_data ? !shreg[7] :
                        recv_ack ? 1'b1 :
                        (state == ST_START) ? q[1] :
                        (state == ST_STOP) ? !q[1] : 1'b0;
    wire round_complete = (state == ST_IDLE);
    logic idle_d, host_sda_low;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            host_sda_low <= 1'b0;
        end else if (ce) begin
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
            host_sda_low <= ctrl.pass_through && !sda_s && !sda_low;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_d <= 1'b1;
            irq <= 1'b0;
        end else if (ce) begin
            idle_d <= round_complete;
            if (hub_irq_route_first && round_complete && !idle_d) begin
                irq <= 1'b1;
            end else if (state_read) begin
                irq <= 1'b0;
            end
        end
    end

    assign status = '{single_write_finished: write_done, target_no_ack: no_ack,
                      zero: 2'h0, round_complete: round_complete};
    assign hub_status = status;
    assign first_irq_pin = irq;
    assign aux_clock_pin_out = 1'b0;
    assign aux_clock_pin_oe_n = !scl_low;
    assign aux_data_pin_out = 1'b0;
    assign aux_data_pin_oe_n = !sda_low;
    assign host_sda_out = 1'b0;
    assign host_sda_oe_n = !host_sda_low;
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the sensor hub master
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hub_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic hub_page_select = 1'b1, hub_irq_route_first = 1'b0, accel_active = 1'b0;
    logic gyro_active = 1'b0, data_ready = 1'b0, second_irq_pin = 1'b0, link_run = 1'b0;
    logic host_scl_in = 1'b1, host_sda_in = 1'b1, second_irq_input_mode, first_irq_pin;
    logic aux_clock_pin_oe_n, aux_data_pin_oe_n, aux_pullup_enable, tgt_drive_n;
    logic aux_pull_n = 1'b1, host_sda_oe_n;
    status_type hub_status;
    wire logic aux_data_pin_in = aux_data_pin_oe_n & tgt_drive_n & aux_pull_n;
    int err_count = 0, num_checks = 0;
    always #5 clk = ~clk;
    // offset keeps link edges away from the sampling clock edges
    initial begin
        #2;
        forever #62.5 if (link_run) host_scl_in = ~host_scl_in;
    end
    sensor_hub_i2c_master sensor_hub_i2c_master_inst (.clk, .rst, .ce, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .hub_page_select, .hub_irq_route_first,
        .accel_active, .gyro_active, .data_ready, .second_irq_pin, .second_irq_input_mode,
        .first_irq_pin, .aux_clock_pin_out(), .aux_clock_pin_oe_n, .aux_data_pin_in,
        .aux_data_pin_out(), .aux_data_pin_oe_n, .aux_pullup_enable, .host_scl_in,
        .host_sda_in, .host_sda_out(), .host_sda_oe_n, .hub_status);
    hub_target hub_target_inst (.scl(aux_clock_pin_oe_n), .sda(aux_data_pin_in),
        .sda_drive_n(tgt_drive_n));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk($sformatf("register %h", a), e, reg_rdata);
    endtask
    task automatic pulse_ready();
        @(negedge clk);
        data_ready = 1'b1;
        @(negedge clk);
        data_ready = 1'b0;
        repeat (20) @(negedge clk);
    endtask
    task automatic wait_idle(input logic v);
        for (int i = 0; i < 70000 && hub_status.round_complete !== v; i++) @(negedge clk);
        chk("round complete", v, hub_status.round_complete);
    endtask
    task automatic test_regs();
        chk("status", 8'h01, hub_status);
        wr(8'h15, 8'h55);
        wr(8'h16, 8'h10);
        wr(8'h17, 8'h01);
        rd(8'h15, 8'h55);
        rd(8'h14, 8'h00);
        wr(8'h14, 8'h2c);
        rd(8'h14, 8'h2c);
        chk("input mode", 8'h01, second_irq_input_mode);
        hub_page_select = 1'b0;
        wr(8'h14, 8'h00);
        rd(8'h22, 8'h00);
        rd(8'h39, 8'h01);
        hub_page_select = 1'b1;
        rd(8'h14, 8'h2c);
        rd(8'h40, 8'h00);
        wr(8'h14, 8'h08);
        rd(8'h14, 8'h08);
        chk("pullup", 8'h01, aux_pullup_enable);
        chk("input mode", 8'h00, second_irq_input_mode);
        $display("registers test done");
    endtask
    task automatic test_idle();
        wr(8'h14, 8'h44);
        pulse_ready();
        chk("status", 8'h01, hub_status);
        wr(8'h14, 8'h40);
        accel_active = 1'b1;
        pulse_ready();
        chk("status", 8'h01, hub_status);
        $display("idle test done");
    endtask
    task automatic test_pass();
        wr(8'h14, 8'h10);
        link_run = 1'b1;
        repeat (3) begin
            @(negedge host_scl_in);
            repeat (5) @(negedge clk);
            chk("aux clock", 8'h00, aux_clock_pin_oe_n);
            @(posedge host_scl_in);
            repeat (5) @(negedge clk);
            chk("aux clock", 8'h01, aux_clock_pin_oe_n);
        end
        link_run = 1'b0;
        aux_pull_n = 1'b0;
        repeat (5) @(negedge clk);
        chk("host data", 8'h00, host_sda_oe_n);
        aux_pull_n = 1'b1;
        repeat (5) @(negedge clk);
        host_sda_in = 1'b0;
        repeat (5) @(negedge clk);
        chk("aux data", 8'h00, aux_data_pin_oe_n);
        chk("host data", 8'h01, host_sda_oe_n);
        host_sda_in = 1'b1;
        repeat (5) @(negedge clk);
        wr(8'h14, 8'h00);
        $display("pass-through test done");
    endtask
    task automatic test_round();
        hub_irq_route_first = 1'b1;
        wr(8'h14, 8'h44);
        @(negedge clk);
        data_ready = 1'b1;
        @(negedge clk);
        data_ready = 1'b0;
        repeat (2) @(negedge clk);
        chk("status", 8'h00, hub_status);
        wait_idle(1'b1);
        repeat (2) @(negedge clk);
        rd(8'h02, 8'h5c);
        rd(8'h03, 8'h00);
        chk("first irq", 8'h01, first_irq_pin);
        hub_page_select = 1'b0;
        rd(8'h39, 8'h01);
        chk("first irq", 8'h00, first_irq_pin);
        hub_page_select = 1'b1;
        $display("read round test done");
    endtask
    task automatic test_nack();
        wr(8'h14, 8'h00);
        repeat (30000) @(negedge clk);
        wr(8'h15, 8'h62);
        wr(8'h21, 8'ha5);
        wr(8'h14, 8'h24);
        second_irq_pin = 1'b1;
        wait_idle(1'b0);
        second_irq_pin = 1'b0;
        wait_idle(1'b1);
        rd(8'h22, 8'h09);
        wr(8'h14, 8'h80);
        wr(8'h14, 8'h00);
        rd(8'h22, 8'h01);
        rd(8'h02, 8'h00);
        rd(8'h15, 8'h00);
        $display("no-ack test done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        test_regs();
        test_idle();
        test_pass();
        test_round();
        test_nack();
        complete_run();
    end
    // two bus rounds plus the disable wait take about 810 us
    initial begin
        #950000;
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
